//--- logic/lpc_regs.vh
// Purpose : Constants for the loop power, poll and clear block
// Assumes : Included by bare name from logic/lpc_core.v
// Notes   : Command codes arrive already decoded as one-cycle strobes
`ifndef LPC_REGS_VH
`define LPC_REGS_VH

// Power function state codes
`define LPC_PWR_OFF      3'h0
`define LPC_PWR_ON       3'h1
`define LPC_PWR_UP       3'h2
`define LPC_PWR_PEND     3'h3
`define LPC_PWR_HOLD     3'h4

// Poll function state codes
`define LPC_POLL_IDLE    2'h0
`define LPC_POLL_STBY    2'h1
`define LPC_POLL_ACT     2'h2

// Poll enable command field positions
`define LPC_PE_BIT_HI    2
`define LPC_PE_BIT_LO    0
`define LPC_PE_SENSE     3

// Reset values and frame width
`define LPC_POLL_BIT_RST 3'h0
`define LPC_FRAME_W      8

`endif

//--- logic/lpc_core.v
// Purpose : Loop device power-down, parallel poll and device clear logic
// Assumes : Frame decoder gives one-cycle strobes on ref_clk; loop_pulse
//           is a raw pin, synchronised here
//           local messages and device inputs are on ref_clk
// Notes   : Full power capability unless minimal_power is tied high;
//           an enable that lands during an active poll keeps the old
//           bit and sense, since the frame in flight must not change
`timescale 1ns/1ns
`include "lpc_regs.vh"

module lpc_core (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  // Capability strap
  input  wire       minimal_power,
  // Loop pin
  input  wire       loop_pulse,
  // Decoded remote messages, one-cycle strobes
  input  wire       msg_strobe,
  input  wire       loop_sleep_command,
  input  wire       ready_for_command_frame,
  input  wire       identify_frame,
  input  wire       poll_enable_command,
  input  wire [7:0] poll_enable_code,
  input  wire       poll_disable_command,
  input  wire       poll_unconfigure_command,
  input  wire       universal_clear_command,
  input  wire       selective_clear_command,
  // Other interface function states
  input  wire       listener_active_state,
  input  wire       controller_active,
  input  wire       acceptor_data_state,
  input  wire       driver_idle,
  input  wire       driver_transfer,
  // Local messages and device
  input  wire       local_force_on,
  input  wire       local_power_off,
  input  wire       local_power_on,
  input  wire       device_status,
  input  wire       device_accepted,
  // Identify frame data path
  input  wire [7:0] idy_data_in,
  output reg  [7:0] idy_data_out,
  // Status outputs
  output reg        off_state,
  output reg        power_on_state,
  output reg        normal_operating_state,
  output reg        down_pending_state,
  output reg        down_hold_state,
  output reg        retransmit_block,
  output reg        poll_standby_state,
  output reg        poll_active_state,
  output reg        clear_active_state
);

  // ********************************************************************
  // Reset release
  // ********************************************************************
  // Assertion is immediate; release takes two edges so no flop sees
  // the end of reset part-way through a clock period
  reg rst_m_r;
  reg rst_n_r;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // ********************************************************************
  // Loop pulse detector
  // ********************************************************************
  // Three stages; second and third agree before an edge counts. The
  // detector is never gated by the power state so the first pulse wakes.
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg pulse_lvl_r;
  // Only s2_r reads s1_r; s1_r may still be settling
  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= loop_pulse;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accepted level of the pin; moves once the last two stages agree
  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      pulse_lvl_r <= 1'b0;
    else if (s2_r == s3_r)
      pulse_lvl_r <= s3_r;
  end

  // ********************************************************************
  // Wake event
  // ********************************************************************
  // One cycle per accepted pin change, only while off or powering on,
  // so ordinary loop traffic never re-enters the power-on state
  reg wake_r;
  reg [2:0] pwr_r;
  reg [2:0] pwr_nxt;
  // Seen one cycle before pulse_lvl_r catches up with the pin
  wire pulse_edge = (s2_r == s3_r) && (s3_r != pulse_lvl_r);
  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      wake_r <= 1'b0;
    else if (minimal_power)
      wake_r <= 1'b0;
    else if (pwr_r == `LPC_PWR_OFF || pwr_r == `LPC_PWR_ON)
      wake_r <= pulse_edge;
    else
      wake_r <= 1'b0;
  end

  // ********************************************************************
  // Power function
  // ********************************************************************
  always @* begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      `LPC_PWR_OFF: begin
        if (!local_power_off && (local_power_on || wake_r))
          pwr_nxt = `LPC_PWR_ON;
      end
      `LPC_PWR_ON: begin
        if (!local_power_on && !wake_r)
          pwr_nxt = `LPC_PWR_UP;
      end
      `LPC_PWR_UP: begin
        if (loop_sleep_command && !controller_active && !minimal_power)
          pwr_nxt = `LPC_PWR_PEND;
      end
      `LPC_PWR_PEND: begin
        if (ready_for_command_frame)
          pwr_nxt = `LPC_PWR_HOLD;
        else if (msg_strobe)
          pwr_nxt = `LPC_PWR_UP;
      end
      `LPC_PWR_HOLD: begin
        if (local_force_on)
          pwr_nxt = `LPC_PWR_UP;
        else if (driver_idle)
          pwr_nxt = `LPC_PWR_OFF;
      end
      default: pwr_nxt = `LPC_PWR_OFF;
    endcase
    // Local power-off beats every transition, a wake included
    if (local_power_off)
      pwr_nxt = `LPC_PWR_OFF;
  end

  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      pwr_r <= `LPC_PWR_ON;
    else
      pwr_r <= pwr_nxt;
  end

  // ********************************************************************
  // Power state outputs
  // ********************************************************************
  // Flags are decoded from the next state so they line up with pwr_r
  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      off_state              <= 1'b0;
      power_on_state         <= 1'b1;
      normal_operating_state <= 1'b0;
      down_pending_state     <= 1'b0;
      down_hold_state        <= 1'b0;
      retransmit_block       <= 1'b0;
    end else begin
      off_state              <= (pwr_nxt == `LPC_PWR_OFF);
      power_on_state         <= (pwr_nxt == `LPC_PWR_ON);
      normal_operating_state <= (pwr_nxt == `LPC_PWR_UP);
      down_pending_state     <= (pwr_nxt == `LPC_PWR_PEND);
      down_hold_state        <= (pwr_nxt == `LPC_PWR_HOLD);
      // The ready frame already in the driver finishes; nothing after
      // it leaves through the hold and the off state, until a force-on or power-on
      retransmit_block       <= (pwr_nxt == `LPC_PWR_HOLD) ||
                                (pwr_nxt == `LPC_PWR_OFF);
    end
  end

  // ********************************************************************
  // Interface function reset
  // ********************************************************************
  // Functions held in first state while off or powering on
  wire funcs_reset = (pwr_nxt == `LPC_PWR_OFF) ||
                     (pwr_nxt == `LPC_PWR_ON);

  // ********************************************************************
  // Parallel poll function
  // ********************************************************************
  reg [1:0] poll_r;
  reg [1:0] poll_nxt;
  reg [2:0] poll_bit_r;
  reg       poll_sense_r;
  // Enable and disable are addressed, so they need the listener active;
  // unconfigure is universal and reaches every device on the loop
  wire      pe_take = poll_enable_command && listener_active_state;
  wire      pe_kill = (poll_disable_command && listener_active_state) ||
                      poll_unconfigure_command;

  always @* begin
    poll_nxt = poll_r;
    case (poll_r)
      `LPC_POLL_IDLE: begin
        if (pe_take)
          poll_nxt = `LPC_POLL_STBY;
      end
      `LPC_POLL_STBY: begin
        if (pe_kill)
          poll_nxt = `LPC_POLL_IDLE;
        else if (identify_frame)
          poll_nxt = `LPC_POLL_ACT;
      end
      `LPC_POLL_ACT: begin
        if (pe_kill)
          poll_nxt = `LPC_POLL_IDLE;
        else if (driver_transfer)
          poll_nxt = `LPC_POLL_STBY;
      end
      default: poll_nxt = `LPC_POLL_IDLE;
    endcase
    // Off and power-on win over any message in the same cycle
    if (funcs_reset)
      poll_nxt = `LPC_POLL_IDLE;
  end

  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      poll_r             <= `LPC_POLL_IDLE;
      poll_standby_state <= 1'b0;
      poll_active_state  <= 1'b0;
    end else begin
      poll_r             <= poll_nxt;
      poll_standby_state <= (poll_nxt == `LPC_POLL_STBY);
      poll_active_state  <= (poll_nxt == `LPC_POLL_ACT);
    end
  end

  // ********************************************************************
  // Poll configuration
  // ********************************************************************
  // Bit number and sense are frozen while a poll is active, so the mask
  // cannot change under the identify frame being forwarded
  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      poll_bit_r   <= `LPC_POLL_BIT_RST;
      poll_sense_r <= 1'b0;
    end else if (funcs_reset) begin
      poll_bit_r   <= `LPC_POLL_BIT_RST;
      poll_sense_r <= 1'b0;
    end else if (pe_take && poll_r != `LPC_POLL_ACT) begin
      poll_bit_r   <= poll_enable_code[`LPC_PE_BIT_HI:`LPC_PE_BIT_LO];
      poll_sense_r <= poll_enable_code[`LPC_PE_SENSE];
    end
  end

  // ********************************************************************
  // Poll response
  // ********************************************************************
  // Response bit: sense 0 sets on false status, sense 1 on true status
  wire       resp_one = poll_sense_r ? device_status : !device_status;
  wire [7:0] resp_mask;
  // One compare per bit: a flat decode of the stored bit number
  genvar gi;
  generate
    for (gi = 0; gi < `LPC_FRAME_W; gi = gi + 1) begin : g_mask
      assign resp_mask[gi] = resp_one && (poll_bit_r == gi);
    end
  endgenerate

  // ********************************************************************
  // Identify frame data path
  // ********************************************************************
  // Every frame takes one register stage, polled or not, so the latency
  // through the device does not depend on the poll state
  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      idy_data_out <= 8'h00;
    else if (poll_nxt == `LPC_POLL_ACT || poll_r == `LPC_POLL_ACT)
      idy_data_out <= idy_data_in | resp_mask;
    else
      idy_data_out <= idy_data_in;
  end

  // ********************************************************************
  // Device clear function
  // ********************************************************************
  // Both commands drive the same single request, so they clear alike.
  // Interface state is never touched here; only the device sees it.
  wire clr_go = universal_clear_command ||
                (selective_clear_command &&
                 listener_active_state);

  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      clear_active_state <= 1'b0;
    else if (funcs_reset)
      clear_active_state <= 1'b0;
    // Set needs idle and clear needs active, so the two never collide
    else if (!clear_active_state && clr_go)
      clear_active_state <= 1'b1;
    else if (clear_active_state && device_accepted &&
             acceptor_data_state)
      clear_active_state <= 1'b0;
  end

endmodule // lpc_core

//--- tb/lpc_core_props.sv
// Purpose: Checker for the loop power, poll and clear block
// Assumes: Bound to lpc_core; one clock domain
// Notes: Frame data checks look one cycle after the data enters
`timescale 1ns/1ns
module lpc_core_props (
  // Clock and reset
  input logic       ref_clk,
  input logic       rstn,
  // Stimulus seen by the core
  input logic       minimal_power,
  input logic       msg_strobe,
  input logic       loop_sleep_command,
  input logic       ready_for_command_frame,
  input logic       universal_clear_command,
  input logic       controller_active,
  input logic       acceptor_data_state,
  input logic       driver_idle,
  input logic       local_force_on,
  input logic       local_power_off,
  input logic       device_accepted,
  input logic [7:0] idy_data_in,
  // Core outputs
  input logic [7:0] idy_data_out,
  input logic       off_state,
  input logic       normal_operating_state,
  input logic       down_pending_state,
  input logic       down_hold_state,
  input logic       retransmit_block,
  input logic       poll_standby_state,
  input logic       poll_active_state,
  input logic       clear_active_state
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_PEND: assert property (
    normal_operating_state && loop_sleep_command && !controller_active
    && !minimal_power && !local_power_off |=> down_pending_state)
    else $error("sleep command not taken");
  AST_HOLD: assert property (
    down_pending_state && msg_strobe && ready_for_command_frame
    && !local_power_off |=> down_hold_state) else $error("no hold");
  AST_ABORT: assert property (
    down_pending_state && msg_strobe && !ready_for_command_frame
    && !local_power_off |=> normal_operating_state) else $error("no abort");
  AST_DOWN: assert property (
    down_hold_state && driver_idle && !local_force_on && !local_power_off
    |=> off_state) else $error("hold did not power off");
  AST_OFF: assert property (
    local_power_off && (normal_operating_state || off_state) |=> off_state)
    else $error("power off not forced");
  AST_BLOCK: assert property (
    down_hold_state || off_state |-> retransmit_block)
    else $error("frames not blocked");
  AST_KEEP: assert property (
    normal_operating_state && !local_power_off
    |=> (idy_data_out & $past(idy_data_in)) == $past(idy_data_in))
    else $error("set bit cleared");
  AST_PASS: assert property (
    normal_operating_state && !poll_standby_state && !poll_active_state
    && !local_power_off |=> idy_data_out == $past(idy_data_in))
    else $error("frame altered");
  AST_CLR: assert property (
    normal_operating_state && universal_clear_command && !device_accepted
    && !local_power_off |=> clear_active_state) else $error("no clear");
  AST_DONE: assert property (
    clear_active_state && device_accepted && acceptor_data_state
    && !universal_clear_command |=> !clear_active_state)
    else $error("clear stuck");
endmodule // lpc_core_props
bind lpc_core lpc_core_props u_props (.*);

//--- tb/lpc_ctrl_model.sv
// Purpose: Loop controller model sending decoded message strobes
// Assumes: Strobe order sleep, ready, identify, enable, disable,
//          unconfigure, universal clear, selective clear; 8 is a no-op
// Notes: The loop pin only moves while waking the loop
`timescale 1ns/1ns
module lpc_ctrl_model (
  // Clock
  input  wire       ref_clk,
  // Decoded messages
  output reg        msg_strobe,
  output reg  [7:0] cmd,
  output reg  [7:0] poll_enable_code,
  // Loop pin
  output reg        loop_pulse
);
  // ************************************************************
  // Message source
  // ************************************************************
  initial begin
    {msg_strobe, cmd, poll_enable_code, loop_pulse} = 18'h0_0000;
  end
  task send(input integer k, input [7:0] code);
    begin
      @(negedge ref_clk);
      msg_strobe = 1'b1;
      cmd = (k < 8) ? (8'h01 << k) : 8'h00;
      poll_enable_code = code;
      @(negedge ref_clk);
      msg_strobe = 1'b0;
      cmd = 8'h00;
      // Stale byte is inverted so a late read shows up
      poll_enable_code = ~code;
    end
  endtask
  // Repeated no-op frames, then exactly one ready frame
  task wake;
    integer n;
    begin
      for (n = 0; n < 4; n = n + 1) begin
        @(negedge ref_clk);
        loop_pulse = ~loop_pulse;
        send(8, 8'h00);
      end
      send(1, 8'h00);
    end
  endtask
endmodule // lpc_ctrl_model

//--- tb/testbench.sv
// Purpose: Self-checking bench for the loop power, poll and clear block
// Assumes: Controller model drives the message strobes
// Notes: Inputs move on the falling edge and are checked there
`timescale 1ns/1ns
module testbench;
  // ************************************************************
  // Signals and helpers
  // ************************************************************
  reg        ref_clk, rstn, minimal_power, listener_active_state;
  reg        controller_active, acceptor_data_state, driver_idle;
  reg        driver_transfer, local_force_on, local_power_off;
  reg        local_power_on, device_status, device_accepted;
  reg  [7:0] idy_data_in, code, exp8;
  reg [31:0] rnd;
  wire [7:0] idy_data_out, cmd, poll_enable_code;
  wire       msg_strobe, loop_pulse, loop_sleep_command;
  wire       ready_for_command_frame, identify_frame, poll_enable_command;
  wire       poll_disable_command, poll_unconfigure_command;
  wire       universal_clear_command, selective_clear_command;
  wire       off_state, power_on_state, normal_operating_state;
  wire       down_pending_state, down_hold_state, retransmit_block;
  wire       poll_standby_state, poll_active_state, clear_active_state;
  wire [5:0] pw = {off_state, power_on_state, normal_operating_state,
                   down_pending_state, down_hold_state, retransmit_block};
  wire [7:0] pc = {5'h00, poll_standby_state, poll_active_state,
                   clear_active_state};
  integer    bad_count, check_count, cyc, i;
  localparam [5:0] OFF = 6'h21, ON = 6'h10, NORM = 6'h08;
  localparam [5:0] PEND = 6'h04, HOLD = 6'h03;
  assign {selective_clear_command, universal_clear_command,
          poll_unconfigure_command, poll_disable_command,
          poll_enable_command, identify_frame, ready_for_command_frame,
          loop_sleep_command} = cmd;
  lpc_core dut (.*);
  lpc_ctrl_model m (.ref_clk(ref_clk), .msg_strobe(msg_strobe), .cmd(cmd),
    .poll_enable_code(poll_enable_code), .loop_pulse(loop_pulse));
  function [7:0] poll_exp(input [7:0] d, input [3:0] c, input s);
    poll_exp = d | ((c[3] == s) ? (8'h01 << c[2:0]) : 8'h00);
  endfunction
  task chk_pw(input [5:0] e);
    begin
      check_count = check_count + 1;
      if (pw !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected state at %0t: exp %h got %h", $time, e, pw);
      end
    end
  endtask
  task chk8(input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected value at %0t: exp %h got %h", $time, e, g);
      end
    end
  endtask
  task wait_pw(input [5:0] e);
    integer n;
    begin
      for (n = 0; n < 60 && pw !== e; n = n + 1) @(negedge ref_clk);
      chk_pw(e);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ************************************************************
  // Clock, timeout and sequence
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    for (cyc = 0; cyc < 3000; cyc = cyc + 1) @(posedge ref_clk);
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    {rstn, minimal_power, listener_active_state, controller_active} = 4'h0;
    {acceptor_data_state, driver_idle, driver_transfer, local_force_on} = 4'h0;
    {local_power_off, local_power_on, device_status, device_accepted} = 4'h0;
    {idy_data_in, bad_count, check_count} = 0;
    rnd = $urandom(32'h238a);
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk_pw(NORM);
    controller_active = 1'b1;
    m.send(0, 8'h00);
    chk_pw(NORM);
    {controller_active, minimal_power} = 2'h1;
    m.send(0, 8'h00);
    chk_pw(NORM);
    minimal_power = 1'b0;
    m.send(0, 8'h00);
    chk_pw(PEND);
    m.send(4, 8'h00);
    chk_pw(NORM);
    m.send(0, 8'h00);
    m.send(1, 8'h00);
    chk_pw(HOLD);
    local_force_on = 1'b1;
    @(negedge ref_clk);
    chk_pw(NORM);
    local_force_on = 1'b0;
    m.send(0, 8'h00);
    m.send(1, 8'h00);
    driver_idle = 1'b1;
    @(negedge ref_clk);
    driver_idle = 1'b0;
    chk_pw(OFF);
    m.wake;
    wait_pw(NORM);
    listener_active_state = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $urandom;
      code = {rnd[7:3], i[2:0]};
      device_status = rnd[8];
      idy_data_in = (i == 0) ? 8'hff : rnd[23:16];
      m.send(3, code);
      chk8(8'h04, pc);
      m.send(2, 8'h00);
      @(negedge ref_clk);
      chk8(8'h02, pc);
      exp8 = poll_exp(idy_data_in, code[3:0], rnd[8]);
      chk8(exp8, idy_data_out);
      driver_transfer = 1'b1;
      @(negedge ref_clk);
      driver_transfer = 1'b0;
      chk8(8'h04, pc);
    end
    for (i = 4; i < 6; i = i + 1) begin
      m.send(3, 8'h08);
      m.send(i, 8'h00);
      m.send(2, 8'h00);
      chk8(8'h00, pc);
    end
    listener_active_state = 1'b0;
    m.send(7, 8'h00);
    chk8(8'h00, pc);
    for (i = 6; i < 8; i = i + 1) begin
      listener_active_state = (i == 7);
      m.send(i, 8'h00);
      chk8(8'h01, pc);
      {device_accepted, acceptor_data_state} = 2'h3;
      @(negedge ref_clk);
      {device_accepted, acceptor_data_state} = 2'h0;
      chk8(8'h00, pc);
    end
    m.send(3, 8'h00);
    local_power_off = 1'b1;
    @(negedge ref_clk);
    chk_pw(OFF);
    chk8(8'h00, pc);
    m.wake;
    chk_pw(OFF);
    {local_power_off, local_power_on} = 2'h1;
    repeat (2) @(negedge ref_clk);
    chk_pw(ON);
    local_power_on = 1'b0;
    wait_pw(NORM);
    chk8(8'h00, pc);
    test_done;
  end
endmodule // testbench
